/* File: ets_pkg.sv */
// constants, field layouts and timing for the engine torque signal encoder
package ets_pkg;
  localparam int          RAW_W        = 12;
  localparam int          TQ_W         = 16;
  localparam logic [11:0] RAW_MAX      = 12'hfff;
  // physical = raw * 0.5 - 848, internal unit is half newton-metres
  localparam logic signed [15:0] RAW_OFFSET = 16'sh06a0;
  localparam logic signed [15:0] SMALL_LIMIT = 16'sh0064;
  localparam logic [15:0] SMALL_TOL    = 16'h000a;
  localparam logic [15:0] PCT_DIV      = 16'h000a;
  localparam logic signed [15:0] FRIC_BASE = 16'sh0028;
  localparam int          FRIC_SPD_SH  = 6;
  localparam int          FRIC_LOAD_SH = 3;
  localparam logic signed [7:0]  COLD_TEMP = 8'sh3c;
  localparam logic signed [15:0] COLD_ADD  = 16'sh0014;
  localparam logic [9:0]  PEDAL_KNEE   = 10'h200;
  localparam int          PEDAL_SH     = 10;
  localparam int          AMB_SH       = 8;
  localparam int          LATENCY      = 2;
  localparam longint      CLK_HZ       = 100000000;
  localparam longint      ACT_DELAY_MS = 30;
  localparam longint      DRV_DELAY_MS = 60;
  localparam longint      MAX_DELAY_MS = 125;
  localparam longint      ACT_CYC      = ACT_DELAY_MS * (CLK_HZ / 1000);
  localparam longint      DRV_CYC      = DRV_DELAY_MS * (CLK_HZ / 1000);
  localparam longint      MAX_CYC      = MAX_DELAY_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [11:0] raw;
    logic        invalid;
  } ets_field_s;

  typedef struct packed {
    logic        inputFail;
    logic        faultLogged;
    logic [15:0] errEst;
  } ets_health_s;
endpackage

/* File: ets_field_enc.sv */
// one torque field: saturation, raw conversion and periodic publication
`timescale 1ns/1ns
module ets_field_enc
  import ets_pkg::*;
#(
  parameter int PERIOD = 1000
)
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic signed [15:0] value,
  input  wire logic               invalid,
  output ets_field_s              field,
  output logic                    update
);
  // the counter needs two cycles between publications
  if (PERIOD < 2)
  begin
    $error("ets_field_enc: PERIOD too small");
  end

  logic [31:0]        cnt_q;
  ets_field_s         field_q;
  logic               update_q;
  logic signed [16:0] shifted;
  logic [11:0]        rawSat;

  always_comb
  begin
    shifted = 17'(value) + 17'(RAW_OFFSET);
    if (shifted < 17'sd0)
      rawSat = 12'h000;
    else if (shifted > $signed({5'h00, RAW_MAX}))
      rawSat = RAW_MAX;
    else
      rawSat = shifted[11:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cnt_q <= 32'h0;
    else if (cnt_q == 32'(PERIOD - 1))
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end

  // value and flag land in one register together
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      field_q  <= '{raw: 12'h000, invalid: 1'b1};
      update_q <= 1'b0;
    end
    else
    begin
      update_q <= (cnt_q == 32'(PERIOD - 1));
      if (cnt_q == 32'(PERIOD - 1))
        field_q <= '{raw: rawSat, invalid: invalid};
    end
  end

  assign field  = field_q;
  assign update = update_q;
endmodule

/* File: ets_encoder.sv */
// engine torque encoder: actual, driver requested and maximum torque fields
`timescale 1ns/1ns
module ets_encoder
  import ets_pkg::*;
#(
  parameter int ACT_PERIOD = int'(ACT_CYC) - LATENCY,
  parameter int DRV_PERIOD = int'(DRV_CYC) - LATENCY,
  parameter int MAX_PERIOD = int'(MAX_CYC) - LATENCY
)
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic signed [15:0] indicatedTq,
  input  wire logic [15:0]        engineSpeed,
  input  wire logic [15:0]        engineLoad,
  input  wire logic signed [7:0]  coolantTemp,
  input  wire logic signed [7:0]  oilTemp,
  input  wire logic [15:0]        waterPumpLoss,
  input  wire logic [15:0]        oilPumpLoss,
  input  wire logic [15:0]        acVarLoss,
  input  wire logic [9:0]         pedalPos,
  input  wire logic               cruiseActive,
  input  wire logic signed [15:0] cruiseTq,
  input  wire logic signed [15:0] wotBaseTq,
  input  wire logic [8:0]         ambientFactor,
  input  ets_health_s             actHealth,
  input  ets_health_s             drvHealth,
  input  ets_health_s             maxHealth,
  output ets_field_s              actField,
  output logic                    actUpdate,
  output ets_field_s              drvField,
  output logic                    drvUpdate,
  output ets_field_s              maxField,
  output logic                    maxUpdate
);
  // each publication counter needs at least two cycles per period
  if (ACT_PERIOD < 2)
  begin
    $error("ets_encoder: ACT_PERIOD too small");
  end
  if (DRV_PERIOD < 2)
  begin
    $error("ets_encoder: DRV_PERIOD too small");
  end
  if (MAX_PERIOD < 2)
  begin
    $error("ets_encoder: MAX_PERIOD too small");
  end

  // allowed error in half newton-metres for a given torque
  function automatic logic [15:0] accBound(input logic signed [15:0] tq);
    logic [15:0] mag;
    mag = tq[15] ? 16'(-tq) : 16'(tq);
    if (mag > $unsigned(SMALL_LIMIT))
      return mag / PCT_DIV;
    else
      return SMALL_TOL;
  endfunction

  function automatic logic signed [15:0] clip16(input logic signed [31:0] v);
    if (v > 32'sh00007fff)
      return 16'sh7fff;
    else if (v < -32'sh00008000)
      return -16'sh8000;
    else
      return v[15:0];
  endfunction

  // progressive pedal curve, 0..1023 in, 0..1022 out
  function automatic logic [10:0] pedalCurve(input logic [9:0] p);
    if (p < PEDAL_KNEE)
      return {2'b00, p[9:1]};
    else
      return 11'(p) + 11'(p[9:1]) - 11'(PEDAL_KNEE);
  endfunction

  // invalid when inputs failed, a fault is logged where one is needed,
  // and the fallback error exceeds the accuracy bound
  function automatic logic flagInvalid(input ets_health_s h, input logic needFault, input logic signed [15:0] tq);
    return h.inputFail && (h.faultLogged || !needFault) && (h.errEst > accBound(tq));
  endfunction

  logic signed [15:0] actTq_q;
  logic signed [15:0] drvTq_q;
  logic signed [15:0] maxTq_q;
  logic               actInv_q;
  logic               drvInv_q;
  logic               maxInv_q;

  logic signed [31:0] friction;
  logic signed [31:0] actSum;
  logic signed [31:0] maxProd;
  logic signed [31:0] pedalProd;
  logic signed [15:0] actTqNow;
  logic signed [15:0] maxTqNow;
  logic signed [15:0] pedalTq;
  logic signed [15:0] drvTqNow;

  // crankshaft torque: map torque less friction (base, speed, load and cold terms) and accessory losses
  always_comb
  begin
    friction = 32'(FRIC_BASE)
             + 32'(engineSpeed >> FRIC_SPD_SH)
             + 32'(engineLoad >> FRIC_LOAD_SH)
             + ((coolantTemp < COLD_TEMP) ? 32'(COLD_ADD) : 32'sh0)
             + ((oilTemp < COLD_TEMP) ? 32'(COLD_ADD) : 32'sh0);
    actSum   = 32'(indicatedTq) - friction
             - 32'(waterPumpLoss) - 32'(oilPumpLoss) - 32'(acVarLoss);
    actTqNow = clip16(actSum);
  end

  // wide-open-throttle torque scaled by the ambient factor
  always_comb
  begin
    maxProd  = (32'(wotBaseTq) * $signed({23'h0, ambientFactor})) >>> AMB_SH;
    maxTqNow = clip16(maxProd);
  end

  // pedal share of available torque, raised to cruiseTq when cruise is active and cruiseTq is higher
  always_comb
  begin
    pedalProd = (32'(maxTqNow) * $signed({21'h0, pedalCurve(pedalPos)})) >>> PEDAL_SH;
    pedalTq   = clip16(pedalProd);
    if (cruiseActive && cruiseTq > pedalTq)
      drvTqNow = cruiseTq;
    else
      drvTqNow = pedalTq;
  end

  // torque values, registered once per cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      actTq_q <= 16'sh0;
    else
      actTq_q <= actTqNow;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      drvTq_q <= 16'sh0;
    else
      drvTq_q <= drvTqNow;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      maxTq_q <= 16'sh0;
    else
      maxTq_q <= maxTqNow;
  end

  // each flag judged on the very torque registered beside it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      actInv_q <= 1'b1;
    else
      actInv_q <= flagInvalid(actHealth, 1'b1, actTqNow);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      drvInv_q <= 1'b1;
    else
      drvInv_q <= flagInvalid(drvHealth, 1'b0, drvTqNow);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      maxInv_q <= 1'b1;
    else
      maxInv_q <= flagInvalid(maxHealth, 1'b1, maxTqNow);
  end

  ets_field_enc #(.PERIOD(ACT_PERIOD)) u_act (
    .sys_clk (sys_clk),
    .reset   (reset),
    .value   (actTq_q),
    .invalid (actInv_q),
    .field   (actField),
    .update  (actUpdate)
  );

  ets_field_enc #(.PERIOD(DRV_PERIOD)) u_drv (
    .sys_clk (sys_clk),
    .reset   (reset),
    .value   (drvTq_q),
    .invalid (drvInv_q),
    .field   (drvField),
    .update  (drvUpdate)
  );

  ets_field_enc #(.PERIOD(MAX_PERIOD)) u_max (
    .sys_clk (sys_clk),
    .reset   (reset),
    .value   (maxTq_q),
    .invalid (maxInv_q),
    .field   (maxField),
    .update  (maxUpdate)
  );
endmodule

/* File: ets_encoder_properties.sv */
// checker of publication timing and flag causes at the torque encoder ports
`timescale 1ns/1ns
module ets_encoder_checker
  import ets_pkg::*;
#(
  parameter int ACT_PERIOD = 8,
  parameter int DRV_PERIOD = 12,
  parameter int MAX_PERIOD = 20
)
(
  input wire logic   sys_clk,
  input wire logic   reset,
  input ets_health_s actHealth,
  input ets_health_s drvHealth,
  input ets_health_s maxHealth,
  input ets_field_s  actField,
  input wire logic   actUpdate,
  input ets_field_s  drvField,
  input wire logic   drvUpdate,
  input ets_field_s  maxField,
  input wire logic   maxUpdate
);
  logic [31:0] actGap_q;
  logic [31:0] drvGap_q;
  logic [31:0] maxGap_q;

  // cycles since each field was last published; periods are far too long for a delay
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      actGap_q <= 32'h0;
    else if (actUpdate)
      actGap_q <= 32'h1;
    else
      actGap_q <= actGap_q + 32'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      drvGap_q <= 32'h0;
    else if (drvUpdate)
      drvGap_q <= 32'h1;
    else
      drvGap_q <= drvGap_q + 32'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      maxGap_q <= 32'h0;
    else if (maxUpdate)
      maxGap_q <= 32'h1;
    else
      maxGap_q <= maxGap_q + 32'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  act_pair_a: assert property ($changed(actField) |-> actUpdate) else $error("act moved alone");
  drv_pair_a: assert property ($changed(drvField) |-> drvUpdate) else $error("drv moved alone");
  max_pair_a: assert property ($changed(maxField) |-> maxUpdate) else $error("max moved alone");
  act_period_a: assert property ((actGap_q == 32'(ACT_PERIOD)) == actUpdate) else $error("act spacing");
  drv_period_a: assert property ((drvGap_q == 32'(DRV_PERIOD)) == drvUpdate) else $error("drv spacing");
  max_period_a: assert property ((maxGap_q == 32'(MAX_PERIOD)) == maxUpdate) else $error("max spacing");
  act_invalid_a: assert property (actUpdate && actField.invalid
    |-> $past(actHealth.inputFail, 2) && $past(actHealth.faultLogged, 2)) else $error("act flag without cause");
  drv_invalid_a: assert property (drvUpdate && $past(drvHealth.inputFail, 2)
    && $past(drvHealth.errEst, 2) == 16'hffff |-> drvField.invalid) else $error("drv flag missed");
  max_invalid_a: assert property (maxUpdate && maxField.invalid
    |-> $past(maxHealth.inputFail, 2) && $past(maxHealth.faultLogged, 2)) else $error("max flag without cause");
endmodule
bind ets_encoder ets_encoder_checker #(.ACT_PERIOD(ACT_PERIOD), .DRV_PERIOD(DRV_PERIOD), .MAX_PERIOD(MAX_PERIOD))
  chk_u (.sys_clk, .reset, .actHealth, .drvHealth, .maxHealth, .actField, .actUpdate, .drvField, .drvUpdate,
  .maxField, .maxUpdate);

/* File: ets_rx_model.sv */
// receiver model: keeps the last maximum torque published with a valid flag
`timescale 1ns/1ns
module ets_rx_model
  import ets_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset,
  input  ets_field_s  field,
  input  wire logic   update,
  output logic [11:0] heldRaw
);
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      heldRaw <= 12'h000;
    else if (update && !field.invalid)
      heldRaw <= field.raw;
  end
endmodule

/* File: engine_torque_signal_encoder_tb.sv */
// self-checking bench for the engine torque signal encoder
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin num_errors++; $display("FAIL %s exp %0h got %0h", n, e, s); end end
module engine_torque_signal_encoder_tb
  import ets_pkg::*;
;
  logic               sys_clk, reset, cruiseActive, actUpdate, drvUpdate, maxUpdate;
  logic signed [15:0] indicatedTq, cruiseTq, wotBaseTq;
  logic [15:0]        engineSpeed, engineLoad, waterPumpLoss, oilPumpLoss, acVarLoss;
  logic signed [7:0]  coolantTemp, oilTemp;
  logic [9:0]         pedalPos;
  logic [8:0]         ambientFactor;
  ets_health_s        actHealth, drvHealth, maxHealth;
  ets_field_s         actField, drvField, maxField;
  logic [12:0]        ex [3], f [3];
  logic [11:0]        heldMax;
  logic [11:0]        maxQ [$];
  logic [2:0]         upd, seen;
  logic [31:0]        lfsr = 32'h00016665;
  string              nm [3] = '{"act", "drv", "max"};
  int                 num_errors = 0, checks_done = 0;
  assign f[0] = actField;
  assign f[1] = drvField;
  assign f[2] = maxField;
  assign upd = {maxUpdate, drvUpdate, actUpdate};
  ets_encoder #(.ACT_PERIOD(8), .DRV_PERIOD(12), .MAX_PERIOD(20)) dut_u (.sys_clk, .reset, .indicatedTq, .engineSpeed,
    .engineLoad, .coolantTemp, .oilTemp, .waterPumpLoss, .oilPumpLoss, .acVarLoss, .pedalPos, .cruiseActive, .cruiseTq,
    .wotBaseTq, .ambientFactor, .actHealth, .drvHealth, .maxHealth, .actField, .actUpdate, .drvField, .drvUpdate,
    .maxField, .maxUpdate);
  ets_rx_model rx_u (.sys_clk, .reset, .field(maxField), .update(maxUpdate), .heldRaw(heldMax));
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic int clip(int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction
  function automatic logic [12:0] fld(int t, logic inv);
    int r;
    r = t + 1696;
    r = r < 0 ? 0 : (r > 4095 ? 4095 : r);
    return {r[11:0], inv};
  endfunction
  function automatic logic bad(int t, logic [15:0] err);
    int m;
    m = t < 0 ? -t : t;
    return int'(err) > (m > 100 ? m / 10 : 10);
  endfunction
  task automatic drive();
    logic [31:0] r [8];
    foreach (r[i]) r[i] = nxt();
    {indicatedTq, engineSpeed, engineLoad, cruiseTq, wotBaseTq} <= {r[0], r[1], r[2][15:0]};
    {waterPumpLoss, oilPumpLoss, acVarLoss} <= {8'h00, r[3][7:0], 8'h00, r[3][15:8], 8'h00, r[3][23:16]};
    {coolantTemp, oilTemp, pedalPos, cruiseActive, ambientFactor} <= {r[4][27:0], r[3][31:24]};
    actHealth <= {r[5][1:0], r[5][2] ? 16'hffff : r[5][31:16]};
    drvHealth <= {r[6][1:0], r[6][2] ? 16'hffff : r[6][31:16]};
    maxHealth <= {r[7][1:0], r[7][2] ? 16'hffff : r[7][31:16]};
  endtask
  task automatic model();
    int a, m, d, p;
    p = int'(pedalPos);
    p = p < 512 ? p >> 1 : p + (p >> 1) - 512;
    a = clip(int'(indicatedTq) - 40 - int'(engineSpeed >> 6) - int'(engineLoad >> 3) - (coolantTemp < 60 ? 20 : 0)
      - (oilTemp < 60 ? 20 : 0) - int'(waterPumpLoss) - int'(oilPumpLoss) - int'(acVarLoss));
    m = clip((int'(wotBaseTq) * int'(ambientFactor)) >>> 8);
    d = (m * p) >>> 10;
    if (cruiseActive && int'(cruiseTq) > d) d = int'(cruiseTq);
    ex[0] = fld(a, actHealth.inputFail & actHealth.faultLogged & bad(a, actHealth.errEst));
    ex[1] = fld(d, drvHealth.inputFail & bad(d, drvHealth.errEst));
    ex[2] = fld(m, maxHealth.inputFail & maxHealth.faultLogged & bad(m, maxHealth.errEst));
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    reset = 1'b1;
    drive();
    repeat (19) @(posedge sys_clk);
    #1 `CHK("reset", 42'h020008002, {actField, actUpdate, drvField, drvUpdate, maxField, maxUpdate})
    @(posedge sys_clk) reset <= 1'b0;
    seen = 3'h7;
    for (int i = 0; i < 40 && seen === 3'h7; i++)
    begin
      @(posedge sys_clk) drive();
      @(posedge sys_clk) model();
      seen = 3'h0;
      for (int k = 2; k < 26 && !seen[2]; k++)
      begin
        @(posedge sys_clk);
        #1;
        for (int j = 0; j < 3; j++)
          if (upd[j] && k > 2)
          begin
            `CHK(nm[j], ex[j], f[j])
            seen[j] = 1'b1;
          end
      end
      `CHK("rx", maxQ.size() > 0 ? maxQ[$] : 12'h000, heldMax)
      if (!ex[2][0]) maxQ.push_back(ex[2][12:1]);
    end
    if (seen !== 3'h7) num_errors++;
    results();
  end
endmodule
